// File: osc_select_defines.vh
// Offsets, field positions, reset values and timing counts for clock select
`ifndef OSC_SELECT_DEFINES_VH
`define OSC_SELECT_DEFINES_VH

// Register byte addresses
`define REG_CONFIG 12'h000
`define REG_CLOCK_DIVISOR_REG 12'h004
`define REG_TUNE 12'h008
`define REG_STATUS 12'h00c
`define REG_CONTROL 12'h010

// Configuration word fields
`define CFG_MODE_LSB 0
`define CFG_PINFN_BIT 2
`define CFG_SRC_LSB 4
`define CFG_RESET 32'h00000074

// Clock divisor fields
`define DIV_POST_LSB 8
`define DIV_RESET 32'h00000000

// Tune field width
`define TUNE_W 6

// Mode encodings
`define MODE_EC 2'h0
`define MODE_XT 2'h1
`define MODE_HS 2'h2
`define MODE_OFF 2'h3

// Initial source encodings
`define SRC_RC 3'h0
`define SRC_RC_PLL 3'h1
`define SRC_PRI 3'h2
`define SRC_PRI_PLL 3'h3
`define SRC_SEC 3'h4
`define SRC_RC_16 3'h6
`define SRC_RC_N 3'h7

// Start-up cycle count and PLL lock default
`define START_CYCLES 11'h400
`define LOCK_CYCLES_DEFAULT 16'h0200

`endif

// File: startup_timer.v
// Start-up cycle timer gating release of one oscillator clock
`timescale 1ns/10ps
`include "osc_select_defines.vh"
module startup_timer (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Control
    input wire restart,
    input wire enable,
    input wire osc_edge,
    // Result
    output reg ready
);
    reg [9:0] count;
    reg active;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 10'h000;
            active <= 1'b0;
            ready <= 1'b0;
        end else if (restart || !enable) begin
            count <= 10'h000;
            active <= 1'b0;
            ready <= 1'b0;
        end else if (!ready && osc_edge) begin
            // Only cycles after the signal toggles are counted
            active <= 1'b1;
            if (active) begin
                count <= count + 10'h001;
                if (count == 10'h3ff) begin
                    ready <= 1'b1;
                end
            end
        end
    end
endmodule // startup_timer

// File: osc_select.v
// Oscillator source selection, start-up gating, pin function and postscaler
`timescale 1ns/10ps
`include "osc_select_defines.vh"
module osc_select #(
    parameter [15:0] LOCK_CYCLES = `LOCK_CYCLES_DEFAULT
) (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Restart events
    input wire brownout,
    input wire wake,
    // Oscillator pins and sources
    input wire osc_in_i,
    input wire sec_osc_i,
    input wire rc_osc_i,
    output reg osc_out_o,
    output reg osc_out_oe,
    output reg osc_in_oe,
    output reg osc_in_gpio,
    input wire osc_out_gpio_o,
    input wire osc_out_gpio_oe,
    input wire osc_in_gpio_o,
    input wire osc_in_gpio_oe,
    // Clock control results
    output reg amp_enable,
    output reg amp_high_gain,
    output reg pll_enable,
    output reg sys_clk_en,
    output reg clock_ready,
    output reg [5:0] rc_tune
);
    localparam ST_WAIT = 2'h0;
    localparam ST_LOCK = 2'h1;
    localparam ST_READY = 2'h2;

    reg [31:0] config_word;
    reg [31:0] clock_divisor_reg;
    reg [5:0] rc_tune_field;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [15:0] lock_count;
    reg restart;
    reg [2:0] in_sync;
    reg [2:0] sec_sync;
    reg [2:0] rc_sync;
    reg [8:0] post_count;
    reg post_en;
    reg div16_en;
    reg [3:0] div16_count;
    reg sys_tick;
    reg instr_clk;
    wire pri_ready;
    wire sec_ready;
    wire [1:0] mode_sel;
    wire osc_out_pin_pin_function;
    wire [2:0] src_sel;
    wire [2:0] post_sel;
    wire crystal;
    wire pri_on;
    wire uses_pll;
    wire src_is_pri;
    wire src_is_rc;
    wire src_ok;
    wire out_free;
    wire apb_wr;
    wire apb_rd;

    // Postscaler terminal count for a code, 1:1 to 1:64 then 1:256
    function [8:0] post_limit;
        input [2:0] sel;
        begin
            if (sel == 3'h7) begin
                post_limit = 9'h0ff;
            end else begin
                post_limit = (9'h001 << sel) - 9'h001;
            end
        end
    endfunction

    assign mode_sel = config_word[`CFG_MODE_LSB+1:`CFG_MODE_LSB];
    assign osc_out_pin_pin_function = config_word[`CFG_PINFN_BIT];
    assign src_sel = config_word[`CFG_SRC_LSB+2:`CFG_SRC_LSB];
    assign post_sel = clock_divisor_reg[`DIV_POST_LSB+2:`DIV_POST_LSB];
    assign crystal = (mode_sel == `MODE_XT) || (mode_sel == `MODE_HS);
    assign pri_on = (mode_sel != `MODE_OFF);
    assign src_is_pri = (src_sel == `SRC_PRI) || (src_sel == `SRC_PRI_PLL);
    assign src_is_rc = (src_sel == `SRC_RC) || (src_sel == `SRC_RC_PLL) ||
                       (src_sel == `SRC_RC_16) || (src_sel == `SRC_RC_N);
    assign uses_pll = (src_sel == `SRC_PRI_PLL) || (src_sel == `SRC_RC_PLL);
    assign src_ok = src_is_rc ? 1'b1 :
                    src_is_pri ? pri_ready :
                    (src_sel == `SRC_SEC) ? sec_ready : 1'b0;
    assign out_free = !crystal;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;

    // Two-flop synchronisers; third stage feeds edge detect only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_sync <= 3'h0;
            sec_sync <= 3'h0;
            rc_sync <= 3'h0;
            restart <= 1'b1;
        end else begin
            in_sync <= {in_sync[1:0], osc_in_i};
            sec_sync <= {sec_sync[1:0], sec_osc_i};
            rc_sync <= {rc_sync[1:0], rc_osc_i};
            restart <= brownout || wake;
        end
    end

    // Primary timer only runs when the primary is enabled in a crystal mode (XT or HS)
    wire pri_ready_xtal;
    startup_timer u_pri_timer (
        .pclk(pclk),
        .presetn(presetn),
        .restart(restart),
        .enable(pri_on && crystal),
        .osc_edge(in_sync[1] && !in_sync[2]),
        .ready(pri_ready_xtal)
    );
    // External clock needs no crystal settling; disabled never ready
    assign pri_ready = pri_on && (crystal ? pri_ready_xtal : 1'b1);

    startup_timer u_sec_timer (
        .pclk(pclk),
        .presetn(presetn),
        .restart(restart),
        .enable(src_sel == `SRC_SEC),
        .osc_edge(sec_sync[1] && !sec_sync[2]),
        .ready(sec_ready)
    );

    // Ready sequence: start-up, then PLL lock when used
    always @* begin
        next_state = state;
        case (state)
            ST_WAIT: begin
                if (src_ok) begin
                    next_state = uses_pll ? ST_LOCK : ST_READY;
                end
            end
            ST_LOCK: begin
                if (lock_count == LOCK_CYCLES) begin
                    next_state = ST_READY;
                end
            end
            ST_READY: begin
                if (!src_ok) begin
                    next_state = ST_WAIT;
                end
            end
            default: begin
                next_state = ST_WAIT;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_WAIT;
            lock_count <= 16'h0000;
        end else if (restart) begin
            state <= ST_WAIT;
            lock_count <= 16'h0000;
        end else begin
            state <= next_state;
            if (state == ST_LOCK) begin
                lock_count <= lock_count + 16'h0001;
            end else begin
                lock_count <= 16'h0000;
            end
        end
    end

    // RC postscaler as an enable pulse on RC edges; clock edge tick
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_count <= 9'h000;
            post_en <= 1'b0;
            div16_en <= 1'b0;
            div16_count <= 4'h0;
            sys_tick <= 1'b0;
            instr_clk <= 1'b0;
        end else begin
            post_en <= 1'b0;
            div16_en <= 1'b0;
            sys_tick <= 1'b0;
            if (rc_sync[1] && !rc_sync[2]) begin
                if (post_count >= post_limit(post_sel)) begin
                    post_count <= 9'h000;
                    post_en <= 1'b1;
                end else begin
                    post_count <= post_count + 9'h001;
                end
                // Own counter: the postscaler count wraps at its own limit
                div16_count <= div16_count + 4'h1;
                div16_en <= (div16_count == 4'hf);
            end
            case (src_sel)
                `SRC_RC_N: sys_tick <= post_en;
                `SRC_RC_16: sys_tick <= div16_en;
                `SRC_RC, `SRC_RC_PLL: sys_tick <= rc_sync[1] && !rc_sync[2];
                `SRC_SEC: sys_tick <= sec_sync[1] && !sec_sync[2];
                default: sys_tick <= in_sync[1] && !in_sync[2];
            endcase
            if (sys_tick && state == ST_READY) begin
                instr_clk <= !instr_clk;
            end
        end
    end

    // Pin functions and control outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_out_o <= 1'b0;
            osc_out_oe <= 1'b0;
            osc_in_oe <= 1'b0;
            osc_in_gpio <= 1'b0;
            amp_enable <= 1'b0;
            amp_high_gain <= 1'b0;
            pll_enable <= 1'b0;
            sys_clk_en <= 1'b0;
            clock_ready <= 1'b0;
            rc_tune <= 6'h00;
        end else begin
            if (out_free && osc_out_pin_pin_function) begin
                osc_out_o <= instr_clk;
                osc_out_oe <= 1'b1;
            end else if (out_free) begin
                osc_out_o <= osc_out_gpio_o;
                osc_out_oe <= osc_out_gpio_oe;
            end else begin
                osc_out_o <= 1'b0;
                osc_out_oe <= 1'b0;
            end
            osc_in_oe <= !pri_on && osc_in_gpio_oe;
            osc_in_gpio <= !pri_on ? in_sync[1] : 1'b0;
            amp_enable <= crystal;
            amp_high_gain <= (mode_sel == `MODE_HS);
            pll_enable <= uses_pll && src_ok;
            sys_clk_en <= sys_tick && state == ST_READY;
            clock_ready <= (state == ST_READY);
            rc_tune <= rc_tune_field;
        end
    end

    // Unused pin drive for the input pin is taken from the GPIO value
    wire osc_in_drive_unused = osc_in_gpio_o;

    // APB slave, zero wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_word <= `CFG_RESET;
            clock_divisor_reg <= `DIV_RESET;
            rc_tune_field <= 6'h00;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (apb_rd) begin
                case (paddr)
                    `REG_CONFIG: prdata <= {25'h0, config_word[6:4], 1'b0,
                                            config_word[2:0]};
                    `REG_CLOCK_DIVISOR_REG: prdata <= {21'h0, post_sel, 8'h00};
                    `REG_TUNE: prdata <= {26'h0, rc_tune_field};
                    `REG_STATUS: prdata <= {26'h0, state, sec_ready,
                                            pri_ready, clock_ready, 1'b0};
                    default: prdata <= 32'h00000000;
                endcase
                pslverr <= (paddr > `REG_STATUS) || (paddr[1:0] != 2'h0);
            end
            if (apb_wr && pready) begin
                case (paddr)
                    `REG_CONFIG: config_word <= {25'h0, pwdata[6:4], 1'b0,
                                                 pwdata[2:0]};
                    `REG_CLOCK_DIVISOR_REG: clock_divisor_reg <= {21'h0,
                                                       pwdata[10:8], 8'h00};
                    `REG_TUNE: rc_tune_field <= pwdata[5:0];
                    default: ;
                endcase
            end
            if (psel && !penable && pwrite) begin
                pslverr <= (paddr > `REG_STATUS) || (paddr[1:0] != 2'h0);
            end
        end
    end
endmodule // osc_select

// File: osc_select_monitor.sv
// Port-level assertions for the oscillator select block
`timescale 1ns/10ps
`include "osc_select_defines.vh"
module osc_select_monitor (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    // Restart and results
    input wire brownout,
    input wire wake,
    input wire osc_out_oe,
    input wire osc_in_oe,
    input wire amp_enable,
    input wire amp_high_gain,
    input wire sys_clk_en,
    input wire clock_ready,
    input wire [5:0] rc_tune
);
    reg [5:0] tune_w;
    reg [2:0] quiet;
    wire tune_wr = psel && penable && pwrite && pready && paddr == `REG_TUNE;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tune_w <= 6'h00;
            quiet <= 3'h0;
        end else begin
            if (tune_wr)
                tune_w <= pwdata[5:0];
            // Restarts and any APB access need a few cycles to settle
            if (psel || brownout || wake)
                quiet <= 3'h0;
            else if (quiet != 3'h7)
                quiet <= quiet + 3'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_answer_next: assert property (psel && !penable |=> pready)
        else $error("No answer one cycle after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("Answer held longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("Error flag without answer");
    chk_tune_output: assert property (tune_wr |-> ##[1:2] rc_tune == tune_w)
        else $error("Trim output does not follow write");
    chk_crystal_pins: assert property (amp_enable |-> !osc_out_oe && !osc_in_oe)
        else $error("Crystal pin driven in crystal mode");
    chk_gain_mode: assert property (amp_high_gain |-> amp_enable)
        else $error("High gain without amplifier");
    chk_clock_gated: assert property (sys_clk_en |-> clock_ready)
        else $error("System clock before ready");
    chk_ready_holds: assert property (clock_ready && quiet == 3'h7 |=> clock_ready)
        else $error("Ready dropped without restart");
endmodule // osc_select_monitor

bind osc_select osc_select_monitor mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .brownout(brownout), .wake(wake),
    .osc_out_oe(osc_out_oe), .osc_in_oe(osc_in_oe),
    .amp_enable(amp_enable), .amp_high_gain(amp_high_gain),
    .sys_clk_en(sys_clk_en), .clock_ready(clock_ready), .rc_tune(rc_tune)
);

// File: osc_source_model.sv
// Far-side sources: a startable crystal and a free-running RC oscillator
`timescale 1ns/10ps
module osc_source_model (
    // Clock
    input wire pclk,
    // Control
    input wire run,
    // Oscillator levels
    output reg xtal,
    output reg rc,
    output reg [31:0] edges
);
    reg [1:0] div;
    initial begin
        div = 2'h0;
        xtal = 1'b0;
        rc = 1'b0;
        edges = 32'h0;
    end
    always @(posedge pclk) begin
        div <= div + 2'h1;
        if (div[0])
            rc <= ~rc;
        // A stopped crystal holds still, so no edges reach the counter
        if (!run)
            edges <= 32'h0;
        else if (div[0]) begin
            xtal <= ~xtal;
            if (!xtal)
                edges <= edges + 32'h1;
        end
    end
endmodule // osc_source_model

// File: primary_and_rc_osc_select_test.sv
// Register-level test of oscillator select with a crystal model
`timescale 1ns/10ps
`include "osc_select_defines.vh"
`define CHECK(got, exp) begin tests_run = tests_run + 1; \
    if ((got) !== (exp)) begin failures = failures + 1; \
    $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end
module primary_and_rc_osc_select_test;
    reg pclk, presetn, psel, penable, pwrite, brownout, wake, run, gpio_oe;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    reg err, prev;
    wire [31:0] prdata, edges;
    wire pready, pslverr, osc_out_o, osc_out_oe, osc_in_oe, osc_in_gpio;
    wire amp_enable, amp_high_gain, pll_enable, sys_clk_en, clock_ready;
    wire xtal, rc;
    wire [5:0] rc_tune;
    integer failures, tests_run, n, k, c, t;
    osc_select #(.LOCK_CYCLES(16'h0004)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .brownout(brownout),
        .wake(wake), .osc_in_i(xtal), .sec_osc_i(xtal), .rc_osc_i(rc),
        .osc_out_o(osc_out_o), .osc_out_oe(osc_out_oe),
        .osc_in_oe(osc_in_oe), .osc_in_gpio(osc_in_gpio),
        .osc_out_gpio_o(1'b1), .osc_out_gpio_oe(gpio_oe),
        .osc_in_gpio_o(1'b1), .osc_in_gpio_oe(gpio_oe),
        .amp_enable(amp_enable), .amp_high_gain(amp_high_gain),
        .pll_enable(pll_enable), .sys_clk_en(sys_clk_en),
        .clock_ready(clock_ready), .rc_tune(rc_tune));
    osc_source_model src (.pclk(pclk), .run(run), .xtal(xtal), .rc(rc),
        .edges(edges));
    task print_verdict;
        begin
            $display("Checks run %0d, mismatches %0d", tests_run, failures);
            if (failures == 0 && tests_run > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do begin
                @(posedge pclk);
            end while (pready !== 1'b1);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rd_chk(input [11:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            `CHECK(rd, exp)
        end
    endtask
    // Restart a primary or secondary source and count crystal edges until ready
    task startup(input [31:0] cfg, input use_wake, input exp_ready);
        begin
            apb(1'b1, `REG_CONFIG, cfg);
            brownout <= !use_wake;
            wake <= use_wake;
            @(posedge pclk);
            brownout <= 1'b0;
            wake <= 1'b0;
            repeat (50) @(posedge pclk);
            `CHECK(clock_ready, 1'b0)
            run <= 1'b1;
            while (edges < 32'd1020) @(posedge pclk);
            `CHECK(clock_ready, 1'b0)
            while (clock_ready !== 1'b1 && edges < 32'd1100) @(posedge pclk);
            `CHECK(clock_ready, exp_ready)
            if (exp_ready)
                `CHECK(edges >= 32'd1025 && edges <= 32'd1032, 1'b1)
            `CHECK(pll_enable, cfg[4])
            run <= 1'b0;
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (80000) @(posedge pclk);
        failures = failures + 1;
        print_verdict;
    end
    initial begin
        {presetn, psel, penable, pwrite, brownout, wake, run, gpio_oe} = 8'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        failures = 0;
        tests_run = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`REG_CONFIG, `CFG_RESET);
        rd_chk(`REG_CLOCK_DIVISOR_REG, `DIV_RESET);
        apb(1'b0, `REG_STATUS, 32'h0);
        `CHECK(rd[1], 1'b1)
        apb(1'b1, `REG_TUNE, 32'hffffffea);
        rd_chk(`REG_TUNE, 32'h0000002a);
        `CHECK(rc_tune, 6'h2a)
        rd_chk(`REG_CONTROL, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        `CHECK({err, rd}, {1'b1, 32'h0})
        for (k = 0; k < 16; k = k + 1) begin
            gpio_oe <= k[3];
            apb(1'b1, `REG_CONFIG, 32'h20 | k[2:0]);
            repeat (4) @(posedge pclk);
            `CHECK(amp_enable, k[1] ^ k[0])
            `CHECK(amp_high_gain, k[1:0] == 2'h2)
            `CHECK(osc_out_oe, (k[1] ^ k[0]) ? 1'b0 : (k[2] | k[3]))
            `CHECK(osc_in_oe, k[1:0] == 2'h3 && k[3])
            if (!k[2] || (k[1] ^ k[0]))
                `CHECK(osc_out_o, !(k[1] ^ k[0]))
        end
        startup(32'h22, 1'b0, 1'b1);
        startup(32'h22, 1'b1, 1'b1);
        startup(32'h31, 1'b0, 1'b1);
        startup(32'h41, 1'b0, 1'b1);
        startup(32'h23, 1'b0, 1'b0);
        apb(1'b1, `REG_CONFIG, `CFG_RESET);
        for (k = 0; k < 8; k = k + 1) begin
            apb(1'b1, `REG_CLOCK_DIVISOR_REG, k << 8);
            repeat (16) @(posedge pclk);
            c = 0;
            t = 0;
            prev = osc_out_o;
            repeat (2048) begin
                @(posedge pclk);
                c = c + sys_clk_en;
                t = t + (osc_out_o && !prev);
                prev = osc_out_o;
            end
            n = 512 >> ((k == 7) ? 8 : k);
            `CHECK(c >= n - 1 && c <= n + 1, 1'b1)
            `CHECK(t >= n / 2 - 1 && t <= n / 2 + 1, 1'b1)
        end
        // Divide-by-16 must not depend on the postscaler setting
        apb(1'b1, `REG_CONFIG, 32'h60);
        repeat (16) @(posedge pclk);
        c = 0;
        repeat (2048) begin
            @(posedge pclk);
            c = c + sys_clk_en;
        end
        `CHECK(c >= 31 && c <= 33, 1'b1)
        apb(1'b1, `REG_CLOCK_DIVISOR_REG, 32'hfffff8ff);
        rd_chk(`REG_CLOCK_DIVISOR_REG, 32'h0);
        print_verdict;
    end
endmodule // primary_and_rc_osc_select_test
